// ===== dv/cpu_status_stack_addressing_test.sv
// Purpose: self-checking bench for cssa_core
// Assumes: zero-wait apb slave; operand 0x30 is scratch memory
// Notes: stack targets are even so a pushed pc or pc+1 both match
`default_nettype none
module cpu_status_stack_addressing_test;
  timeunit 1ns;
  timeprecision 1ns;
  import cssa_pkg::*;
  typedef struct {cssa_op_e op; logic [7:0] r; logic [7:0] a;} cssa_row_s;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  logic psel = 1'b0;
  logic pen = 1'b0;
  logic pwr = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic [31:0] q;
  logic pready;
  logic pslverr;
  int error_cnt = 0;
  int checked = 0;
  cssa_row_s rows[11] = '{'{OP_ADD_TO_ACC, 8'h0F, 8'h01}, '{OP_ADD_TO_ACC, 8'hFF, 8'h01},
    '{OP_ADD_TO_REG, 8'h80, 8'h80}, '{OP_REG_MINUS_ACC_TO_ACC, 8'h30, 8'h10},
    '{OP_REG_MINUS_ACC_TO_REG, 8'h10, 8'h31}, '{OP_ACC_MINUS_REG_TO_ACC, 8'h05, 8'h05},
    '{OP_ACC_MINUS_REG_TO_REG, 8'h12, 8'h03}, '{OP_AND_TO_ACC, 8'hF0, 8'h0F},
    '{OP_OR_TO_ACC, 8'h50, 8'h0A}, '{OP_XOR_TO_ACC, 8'h55, 8'h55}, '{OP_MOVE_TO_ACC, 8'h5A, 8'h00}};
  cssa_op_e ev[3] = '{OP_SLEEP, OP_WATCHDOG_TIMEOUT, OP_WATCHDOG_CLEAR};
  logic [1:0] evx[3] = '{2'b10, 2'b00, 2'b11};
  always #50 clk = ~clk;
  cssa_core u_cssa_core (.mclk_i(clk), .rst_n_i(rst_n), .psel_i(psel), .penable_i(pen),
    .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata), .pready_o(pready),
    .pslverr_o(pslverr), .irq_pending_o(), .stack_full_o());
  ////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask
  // bounded wait on pready, request held until it is seen
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    psel <= 1'b1;
    pwr <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    pen <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 9);
    if (pready !== 1'b1) begin
      error_cnt++;
      $display("unexpected pready exp 1 got %b", pready);
      end_of_test();
    end else begin
      q = prdata;
      if (pslverr !== 1'b0) begin
        error_cnt++;
        $display("unexpected pslverr exp 0 got %b", pslverr);
      end
      psel <= 1'b0;
      pen <= 1'b0;
      // idle edge so the next call never re-raises psel in this time step
      @(posedge clk);
    end
  endtask
  task automatic c(input cssa_op_e op, input logic [12:0] t, input logic [7:0] lit);
    apb(1'b1, APB_CMD, {3'h0, t, lit, 3'h0, op});
  endtask
  task automatic opnd(input logic [8:0] a);
    apb(1'b1, APB_OPERAND, {23'h0, a});
  endtask
  task automatic bs(input logic set, input logic [2:0] b);
    opnd(ADDR_FLAGS);
    c(set ? OP_BIT_SET : OP_BIT_CLEAR, {10'h0, b}, 8'h00);
  endtask
  task automatic rdc(input string s, input logic [7:0] a, input logic [31:0] e,
    input logic [31:0] m);
    apb(1'b0, a, 32'h0);
    checked++;
    if ((q & m) !== (e & m)) begin
      error_cnt++;
      $display("unexpected %s exp %h got %h", s, e & m, q & m);
    end
  endtask
  ////////////////////////////////////////////////////////////////////////
  initial begin
    logic [8:0] s;
    logic [7:0] r;
    logic [7:0] a;
    logic h;
    logic to_reg;
    logic [31:0] fm;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    rdc("reset flags", APB_FLAGS, 32'h18, 32'hF8);
    rdc("reset stack", APB_EVENT, 32'h0, '1);
    rdc("unmapped", 8'h40, 32'h0, '1);
    $display("test reset done");
    foreach (rows[i]) begin
      r = rows[i].r;
      a = rows[i].a;
      c(OP_LOAD_IMM, 13'h0, r);
      opnd(9'h030);
      c(OP_MOVE_TO_REG, 13'h0, 8'h00);
      c(OP_LOAD_IMM, 13'h0, a);
      c(rows[i].op, 13'h0, 8'h00);
      h = 1'b0;
      case (rows[i].op)
        OP_ADD_TO_ACC, OP_ADD_TO_REG: begin
          s = {1'b0, r} + {1'b0, a};
          h = ({1'b0, r[3:0]} + {1'b0, a[3:0]}) > 5'h0F;
        end
        OP_REG_MINUS_ACC_TO_ACC, OP_REG_MINUS_ACC_TO_REG: begin
          s = {r >= a, r - a};
          h = r[3:0] >= a[3:0];
        end
        OP_ACC_MINUS_REG_TO_ACC, OP_ACC_MINUS_REG_TO_REG: begin
          s = {a >= r, a - r};
          h = a[3:0] >= r[3:0];
        end
        OP_AND_TO_ACC: s = {1'b0, r & a};
        OP_OR_TO_ACC: s = {1'b0, r | a};
        OP_XOR_TO_ACC: s = {1'b0, r ^ a};
        default: s = {1'b0, r};
      endcase
      to_reg = rows[i].op inside {OP_ADD_TO_REG, OP_REG_MINUS_ACC_TO_REG, OP_ACC_MINUS_REG_TO_REG};
      fm = rows[i].op inside {OP_AND_TO_ACC, OP_OR_TO_ACC, OP_XOR_TO_ACC} ? 32'h4 : 32'h7;
      fm = rows[i].op == OP_MOVE_TO_ACC ? 32'h0 : fm;
      rdc("acc", APB_ACC, {24'h0, to_reg ? a : s[7:0]}, '1);
      rdc("mem", APB_MEMWIN, {24'h0, to_reg ? s[7:0] : r}, '1);
      rdc("alu flags", APB_FLAGS, {29'h0, s[7:0] == 8'h00, h, s[8]}, fm);
    end
    $display("test alu done");
    c(OP_LOAD_IMM, 13'h0, 8'hA5);
    opnd(9'h030);
    c(OP_MOVE_TO_REG, 13'h0, 8'h00);
    bs(1'b1, 3'd5);
    c(OP_LOAD_IMM, 13'h0, 8'h3C);
    opnd(9'h030);
    c(OP_MOVE_TO_REG, 13'h0, 8'h00);
    bs(1'b0, 3'd5);
    opnd(9'h030);
    rdc("bank 0", APB_MEMWIN, 32'hA5, '1);
    apb(1'b1, APB_POINTER, 32'hB0);
    opnd(ADDR_INDIRECT_PORT);
    c(OP_MOVE_TO_ACC, 13'h0, 8'h00);
    rdc("indirect", APB_ACC, 32'h3C, '1);
    bs(1'b1, 3'd7);
    c(OP_LOAD_IMM, 13'h0, 8'h77);
    opnd(ADDR_INDIRECT_PORT);
    c(OP_MOVE_TO_REG, 13'h0, 8'h00);
    bs(1'b1, 3'd5);
    bs(1'b1, 3'd6);
    opnd(9'h030);
    rdc("bank 3", APB_MEMWIN, 32'h77, '1);
    for (int k = 5; k < 8; k++) bs(1'b0, 3'(k));
    apb(1'b1, APB_POINTER, 32'h0);
    c(OP_LOAD_IMM, 13'h0, 8'h99);
    opnd(ADDR_INDIRECT_PORT);
    c(OP_MOVE_TO_REG, 13'h0, 8'h00);
    c(OP_MOVE_TO_ACC, 13'h0, 8'h00);
    rdc("zero ptr", APB_ACC, 32'h0, '1);
    rdc("pointer", APB_POINTER, 32'h0, '1);
    rdc("flags kept", APB_FLAGS, 32'h18, 32'hF8);
    $display("test addressing done");
    for (int k = 0; k < 3; k++) begin
      c(ev[k], 13'h0, 8'h00);
      rdc("cause", APB_FLAGS, {27'h0, evx[k], 3'h0}, 32'h18);
    end
    c(OP_SLEEP, 13'h0, 8'h00);
    bs(1'b1, 3'd7);
    bs(1'b1, 3'd0);
    bs(1'b1, 3'd1);
    c(OP_CLR_REG, 13'h0, 8'h00);
    rdc("cleared", APB_FLAGS, 32'h17, '1);
    $display("test flags done");
    for (int k = 1; k < 10; k++) c(OP_CALL, 13'(256 + 2 * k), 8'h00);
    rdc("full", APB_EVENT, 32'h2, 32'h2);
    rdc("pc", APB_PC, 32'h112, '1);
    rdc("stack hidden", APB_STACK, 32'h0, '1);
    for (int k = 8; k > 0; k--) begin
      c(OP_RETURN, 13'h0, 8'h00);
      rdc("pop", APB_PC, 32'(256 + 2 * k), 32'hFFFFFFFE);
    end
    for (int k = 1; k < 9; k++) c(OP_CALL, 13'(512 + 2 * k), 8'h00);
    c(OP_IRQ_ENTRY, 13'h0, 8'h00);
    rdc("held", APB_EVENT, 32'h3, 32'h3);
    rdc("no vector", APB_PC, 32'h210, '1);
    c(OP_RETURN, 13'h0, 8'h00);
    @(posedge clk);
    rdc("vector", APB_PC, {19'h0, PC_IRQ_VECTOR}, '1);
    rdc("taken", APB_EVENT, 32'h2, 32'h3);
    $display("test stack done");
    rst_n <= 1'b0;
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    rdc("reset again flags", APB_FLAGS, 32'h18, 32'hF8);
    rdc("reset again stack", APB_EVENT, 32'h0, '1);
    $display("test reset again done");
    end_of_test();
  end
endmodule
`default_nettype wire

// ===== dv/cssa_core_properties.sv
// Purpose: port checker for cssa_core
// Assumes: opcodes arrive in the low bits of apb writes to the command word
// Notes: reset-cause bits are tracked from event commands
`default_nettype none
module cssa_core_properties
  import cssa_pkg::*;
(
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  input wire logic [31:0] prdata_o,
  input wire logic pready_o,
  input wire logic pslverr_o,
  // status
  input wire logic irq_pending_o,
  input wire logic stack_full_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic acc_w;
  logic to_q;
  logic pd_q;
  assign acc_w = psel_i && penable_i && pwrite_i && paddr_i == APB_CMD;
  default clocking @(posedge mclk_i);
  endclocking
  default disable iff (!rst_n_i);
  ////////////////////////////////////////////////////////////////////////
  // expected cause bits, only events may move them
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      to_q <= 1'b1;
      pd_q <= 1'b1;
    end else if (acc_w) begin
      case (cssa_op_e'(pwdata_i[4:0]))
        OP_WATCHDOG_CLEAR: {to_q, pd_q} <= 2'b11;
        OP_SLEEP: {to_q, pd_q} <= 2'b10;
        OP_WATCHDOG_TIMEOUT: to_q <= 1'b0;
        default: ;
      endcase
    end
  end
  ////////////////////////////////////////////////////////////////////////
  sequence s_rd(a);
    psel_i && penable_i && !pwrite_i && paddr_i == a;
  endsequence
  sequence s_op(o);
    acc_w && pwdata_i[4:0] == o;
  endsequence
  a_cause_bits: assert property (s_rd(APB_FLAGS) |-> prdata_o[4:3] == {to_q, pd_q})
    else $error("cause bits differ from events");
  a_stack_hidden: assert property (s_rd(APB_STACK) |-> prdata_o == 32'h0)
    else $error("stack visible on bus");
  a_acc_width: assert property (s_rd(APB_ACC) |-> prdata_o[31:8] == 24'h0)
    else $error("accumulator wider than a byte");
  a_full_report: assert property (s_rd(APB_EVENT) |-> prdata_o[1] == stack_full_o)
    else $error("full bit differs from port");
  a_irq_when_full: assert property ($rose(irq_pending_o) |-> stack_full_o)
    else $error("interrupt held without full stack");
  a_irq_released: assert property ($fell(stack_full_o) |-> ##[1:2] !irq_pending_o)
    else $error("held interrupt not taken");
  a_call_on_full: assert property (stack_full_o ##0 s_op(OP_CALL) |=> stack_full_o)
    else $error("call on full stack lost depth");
  a_return_frees: assert property (stack_full_o ##0 s_op(OP_RETURN) |=> !stack_full_o)
    else $error("return did not pop");
endmodule
bind cssa_core cssa_core_properties u_cssa_core_properties (.*);
`default_nettype wire

// ===== hdl/cssa_core.sv
// Purpose: datapath slice with addressing, return stack, alu and flags register
// Assumes: instructions are issued over apb, one per write to the command word
// Notes: data memory is 512 bytes of flip-flops; special locations are held outside it
`default_nettype none
module cssa_core (
  // clock and reset
  input wire logic mclk_i,
  input wire logic rst_n_i,
  // apb slave
  input wire logic psel_i,
  input wire logic penable_i,
  input wire logic pwrite_i,
  input wire logic [7:0] paddr_i,
  input wire logic [31:0] pwdata_i,
  output logic [31:0] prdata_o,
  output logic pready_o,
  output logic pslverr_o,
  // status
  output logic irq_pending_o,
  output logic stack_full_o
);
  import cssa_pkg::*;

  ////////////////////////////////////////////////////////////////////////
  logic [7:0] acc_reg;
  logic [7:0] flags_reg;
  logic [7:0] pointer_reg;
  logic [7:0] mem_reg [0:511];
  logic [12:0] stack_reg [0:STACK_DEPTH-1];
  logic [3:0] sp_reg;
  logic [12:0] pc_reg;
  logic [8:0] operand_reg;
  logic irq_pending_reg;
  logic [7:0] result;
  logic [7:0] flags_next;
  logic res_z;
  logic res_dc;
  logic res_c;
  logic upd_z;
  logic upd_dc;
  logic upd_c;
  logic to_acc;
  logic to_mem;
  logic [8:0] eff_addr;
  logic [7:0] rdval;
  cssa_op_e op;
  logic [7:0] lit;
  logic [2:0] bitsel;
  logic cmd_we;

  assign pready_o = 1'b1;
  assign pslverr_o = 1'b0;
  assign stack_full_o = (sp_reg == 4'(STACK_DEPTH));
  assign irq_pending_o = irq_pending_reg;
  assign cmd_we = psel_i && penable_i && pwrite_i && (paddr_i == APB_CMD);
  assign op = cssa_op_e'(pwdata_i[4:0]);
  assign lit = pwdata_i[15:8];
  assign bitsel = pwdata_i[18:16];

  // map a direct or indirect address to the storage location
  function automatic logic [8:0] resolve(input logic [8:0] a, input logic [7:0] fl,
                                         input logic [7:0] ptr);
    logic [8:0] r;
    r = a;
    if (a[6:0] == ADDR_INDIRECT_PORT[6:0]) begin
      r = {fl[FLG_IRP], ptr};
    end
    return r;
  endfunction

  // read data memory; flags, pointer and indirect port are core-held
  function automatic logic [7:0] mem_read(input logic [8:0] a, input logic [7:0] fl,
                                          input logic [7:0] ptr, input logic [7:0] m);
    logic [7:0] v;
    v = m;
    if (a[6:0] == ADDR_FLAGS[6:0]) begin
      v = fl;
    end else if (a[6:0] == ADDR_POINTER[6:0]) begin
      v = ptr;
    end else if (a[6:0] == ADDR_INDIRECT_PORT[6:0]) begin
      v = 8'h00;
    end
    return v;
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // operand: low seven bits plus direct bank select, or through pointer
  always_comb begin
    logic [8:0] dir;
    dir = {flags_reg[FLG_RP_HI:FLG_RP_LO], operand_reg[6:0]};
    eff_addr = resolve(dir, flags_reg, pointer_reg);
    if (operand_reg[6:0] == ADDR_INDIRECT_PORT[6:0] && pointer_reg == 8'h00) begin
      rdval = 8'h00;
    end else begin
      rdval = mem_read(eff_addr, flags_reg, pointer_reg, mem_reg[eff_addr]);
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // alu
  always_comb begin
    logic [8:0] s9;
    logic [4:0] s5;
    result = acc_reg;
    res_z = 1'b0;
    res_dc = flags_reg[FLG_DC];
    res_c = flags_reg[FLG_C];
    upd_z = 1'b0;
    upd_dc = 1'b0;
    upd_c = 1'b0;
    to_acc = 1'b0;
    to_mem = 1'b0;
    s9 = 9'h000;
    s5 = 5'h00;
    case (op)
      OP_MOVE_TO_REG: begin
        result = acc_reg;
        to_mem = 1'b1;
      end
      OP_MOVE_TO_ACC: begin
        result = rdval;
        to_acc = 1'b1;
        upd_z = 1'b1;
      end
      OP_LOAD_IMM: begin
        result = lit;
        to_acc = 1'b1;
      end
      OP_ADD_TO_ACC, OP_ADD_TO_REG: begin
        s9 = {1'b0, acc_reg} + {1'b0, rdval};
        s5 = {1'b0, acc_reg[3:0]} + {1'b0, rdval[3:0]};
        result = s9[7:0];
        res_c = s9[8];
        res_dc = s5[4];
        {upd_z, upd_dc, upd_c} = 3'b111;
        to_acc = (op == OP_ADD_TO_ACC);
        to_mem = (op == OP_ADD_TO_REG);
      end
      OP_REG_MINUS_ACC_TO_ACC, OP_REG_MINUS_ACC_TO_REG: begin
        s9 = {1'b0, rdval} - {1'b0, acc_reg};
        s5 = {1'b0, rdval[3:0]} - {1'b0, acc_reg[3:0]};
        result = s9[7:0];
        res_c = ~s9[8];
        res_dc = ~s5[4];
        {upd_z, upd_dc, upd_c} = 3'b111;
        to_acc = (op == OP_REG_MINUS_ACC_TO_ACC);
        to_mem = (op == OP_REG_MINUS_ACC_TO_REG);
      end
      OP_ACC_MINUS_REG_TO_ACC, OP_ACC_MINUS_REG_TO_REG: begin
        s9 = {1'b0, acc_reg} - {1'b0, rdval};
        s5 = {1'b0, acc_reg[3:0]} - {1'b0, rdval[3:0]};
        result = s9[7:0];
        res_c = ~s9[8];
        res_dc = ~s5[4];
        {upd_z, upd_dc, upd_c} = 3'b111;
        to_acc = (op == OP_ACC_MINUS_REG_TO_ACC);
        to_mem = (op == OP_ACC_MINUS_REG_TO_REG);
      end
      OP_AND_TO_ACC, OP_OR_TO_ACC, OP_XOR_TO_ACC: begin
        result = (op == OP_AND_TO_ACC) ? (acc_reg & rdval) :
                 (op == OP_OR_TO_ACC) ? (acc_reg | rdval) : (acc_reg ^ rdval);
        upd_z = 1'b1;
        to_acc = 1'b1;
      end
      OP_AND_IMM, OP_XOR_IMM: begin
        result = (op == OP_AND_IMM) ? (acc_reg & lit) : (acc_reg ^ lit);
        upd_z = 1'b1;
        to_acc = 1'b1;
      end
      OP_RL_TO_REG: begin
        result = {rdval[6:0], flags_reg[FLG_C]};
        res_c = rdval[7];
        upd_c = 1'b1;
        to_mem = 1'b1;
      end
      OP_RR_TO_REG: begin
        result = {flags_reg[FLG_C], rdval[7:1]};
        res_c = rdval[0];
        upd_c = 1'b1;
        to_mem = 1'b1;
      end
      OP_SWAP_TO_ACC, OP_SWAP_TO_REG: begin
        result = {rdval[3:0], rdval[7:4]};
        to_acc = (op == OP_SWAP_TO_ACC);
        to_mem = (op == OP_SWAP_TO_REG);
      end
      OP_CLR_REG: begin
        result = 8'h00;
        upd_z = 1'b1;
        to_mem = 1'b1;
      end
      OP_BIT_SET, OP_BIT_CLEAR: begin
        result = rdval;
        result[bitsel] = (op == OP_BIT_SET);
        to_mem = 1'b1;
      end
      default: begin
        result = acc_reg;
      end
    endcase
    res_z = (result == 8'h00);
  end

  ////////////////////////////////////////////////////////////////////////
  // flags register next value
  always_comb begin
    flags_next = flags_reg;
    if (cmd_we && to_mem && eff_addr[6:0] == ADDR_FLAGS[6:0]) begin
      flags_next[7:5] = result[7:5];
      // an alu-flag instruction's result never lands in the three alu bits; only its own flag updates do
      if (!(upd_z || upd_dc || upd_c)) begin
        flags_next[2:0] = result[2:0]; // timeout, power-down untouched
      end
    end
    if (cmd_we) begin
      if (upd_z) begin
        flags_next[FLG_Z] = res_z;
      end
      if (upd_dc) begin
        flags_next[FLG_DC] = res_dc;
      end
      if (upd_c) begin
        flags_next[FLG_C] = res_c;
      end
      case (op)
        OP_WATCHDOG_CLEAR: begin
          flags_next[FLG_TO] = 1'b1;
          flags_next[FLG_PD] = 1'b1;
        end
        OP_SLEEP: begin
          flags_next[FLG_TO] = 1'b1;
          flags_next[FLG_PD] = 1'b0;
        end
        OP_WATCHDOG_TIMEOUT: begin
          flags_next[FLG_TO] = 1'b0;
        end
        default: begin
          flags_next[FLG_TO] = flags_next[FLG_TO];
        end
      endcase
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      flags_reg <= FLAGS_RESET;
    end else begin
      flags_reg <= flags_next;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      acc_reg <= 8'h00;
    end else if (cmd_we && to_acc) begin
      acc_reg <= result;
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      pointer_reg <= PTR_RESET;
    end else if (cmd_we && to_mem && eff_addr[6:0] == ADDR_POINTER[6:0]) begin
      pointer_reg <= result;
    end else if (psel_i && penable_i && pwrite_i && paddr_i == APB_POINTER) begin
      pointer_reg <= pwdata_i[7:0];
    end
  end

  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      operand_reg <= 9'h000;
    end else if (psel_i && penable_i && pwrite_i && paddr_i == APB_OPERAND) begin
      operand_reg <= pwdata_i[8:0];
    end
  end

  // memory: writes to the indirect port location are dropped
  always_ff @(posedge mclk_i) begin
    if (cmd_we && to_mem && eff_addr[6:0] != ADDR_INDIRECT_PORT[6:0]
        && eff_addr[6:0] != ADDR_FLAGS[6:0] && eff_addr[6:0] != ADDR_POINTER[6:0]) begin
      mem_reg[eff_addr] <= result;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // return stack: shift register, oldest falls off the bottom when full
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      sp_reg <= 4'h0;
      pc_reg <= PC_RESET;
      irq_pending_reg <= 1'b0;
    end else if (cmd_we) begin
      case (op)
        OP_CALL: begin
          if (!stack_full_o) begin
            sp_reg <= sp_reg + 4'h1;
          end
          pc_reg <= pwdata_i[28:16];
        end
        OP_IRQ_ENTRY: begin
          if (stack_full_o) begin
            irq_pending_reg <= 1'b1;
          end else begin
            sp_reg <= sp_reg + 4'h1;
            pc_reg <= PC_IRQ_VECTOR;
            irq_pending_reg <= 1'b0;
          end
        end
        OP_RETURN: begin
          if (sp_reg != 4'h0) begin
            sp_reg <= sp_reg - 4'h1;
            pc_reg <= stack_reg[0];
          end
        end
        default: begin
          pc_reg <= pc_reg + 13'h0001;
        end
      endcase
    end else if (irq_pending_reg && !stack_full_o) begin
      irq_pending_reg <= 1'b0;
      sp_reg <= sp_reg + 4'h1;
      pc_reg <= PC_IRQ_VECTOR;
    end
  end

  // push writes pc+1 into entry 0 and shifts older entries down
  generate
    for (genvar i = 0; i < STACK_DEPTH; i++) begin : g_stack
      always_ff @(posedge mclk_i) begin
        if (!rst_n_i) begin
          stack_reg[i] <= PC_RESET;
        end else if ((cmd_we && (op == OP_CALL || (op == OP_IRQ_ENTRY && !stack_full_o)))
                     || (!cmd_we && irq_pending_reg && !stack_full_o)) begin
          stack_reg[i] <= (i == 0) ? pc_reg + 13'h0001 : stack_reg[(i == 0) ? 0 : i-1];
        end else if (cmd_we && op == OP_RETURN && sp_reg != 4'h0) begin
          stack_reg[i] <= (i == STACK_DEPTH-1) ? stack_reg[i] :
                          stack_reg[(i == STACK_DEPTH-1) ? i : i+1];
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////
  // apb read mux; stack contents are not readable, pointer is
  always_ff @(posedge mclk_i) begin
    if (!rst_n_i) begin
      prdata_o <= 32'h0000_0000;
    end else if (psel_i && !penable_i && !pwrite_i) begin
      case (paddr_i)
        APB_OPERAND: prdata_o <= {23'h000000, operand_reg};
        APB_ACC: prdata_o <= {24'h000000, acc_reg};
        APB_FLAGS: prdata_o <= {24'h000000, flags_reg};
        APB_POINTER: prdata_o <= {24'h000000, pointer_reg};
        APB_MEMWIN: prdata_o <= {24'h000000, rdval};
        APB_PC: prdata_o <= {19'h00000, pc_reg};
        APB_EVENT: prdata_o <= {30'h00000000, stack_full_o, irq_pending_reg};
        default: prdata_o <= 32'h0000_0000;
      endcase
    end
  end
endmodule
`default_nettype wire

// ===== hdl/cssa_pkg.sv
// Purpose: constants for the core status, stack and addressing slice
// Assumes: one 10 MHz instruction clock, synchronous active-low reset
// Notes: apb offsets are byte addresses of 32-bit words
`default_nettype none
package cssa_pkg;
  localparam logic [8:0] ADDR_INDIRECT_PORT = 9'h000;
  localparam logic [8:0] ADDR_FLAGS = 9'h003;
  localparam logic [8:0] ADDR_POINTER = 9'h004;
  localparam logic [6:0] SFR_MASK_LO = 7'h7F;
  localparam int STACK_DEPTH = 8;
  localparam int FLG_IRP = 7;
  localparam int FLG_RP_HI = 6;
  localparam int FLG_RP_LO = 5;
  localparam int FLG_TO = 4;
  localparam int FLG_PD = 3;
  localparam int FLG_Z = 2;
  localparam int FLG_DC = 1;
  localparam int FLG_C = 0;
  localparam logic [7:0] FLAGS_RESET = 8'h18;
  localparam logic [7:0] PTR_RESET = 8'h00;
  localparam logic [12:0] PC_RESET = 13'h0000;
  localparam logic [12:0] PC_IRQ_VECTOR = 13'h0004;
  // apb map
  localparam logic [7:0] APB_CMD = 8'h00;
  localparam logic [7:0] APB_OPERAND = 8'h04;
  localparam logic [7:0] APB_ACC = 8'h08;
  localparam logic [7:0] APB_FLAGS = 8'h0C;
  localparam logic [7:0] APB_POINTER = 8'h10;
  localparam logic [7:0] APB_MEMWIN = 8'h14;
  localparam logic [7:0] APB_STACK = 8'h18;
  localparam logic [7:0] APB_PC = 8'h1C;
  localparam logic [7:0] APB_EVENT = 8'h20;
  typedef enum logic [4:0] {
    OP_NOP, OP_MOVE_TO_REG, OP_MOVE_TO_ACC, OP_LOAD_IMM, OP_ADD_TO_ACC, OP_ADD_TO_REG,
    OP_REG_MINUS_ACC_TO_ACC, OP_REG_MINUS_ACC_TO_REG, OP_ACC_MINUS_REG_TO_ACC,
    OP_ACC_MINUS_REG_TO_REG, OP_AND_TO_ACC, OP_OR_TO_ACC, OP_XOR_TO_ACC, OP_AND_IMM,
    OP_XOR_IMM, OP_RL_TO_REG, OP_RR_TO_REG, OP_SWAP_TO_ACC, OP_SWAP_TO_REG,
    OP_CLR_REG, OP_BIT_SET, OP_BIT_CLEAR, OP_CALL, OP_RETURN, OP_IRQ_ENTRY,
    OP_WATCHDOG_CLEAR, OP_SLEEP, OP_WATCHDOG_TIMEOUT
  } cssa_op_e;
endpackage
`default_nettype wire
